// *** design/pci_bridge_cfg.svh ***
// offsets, field positions, reset values and counts of the pci bridge block
`ifndef PCI_BRIDGE_CFG_SVH
`define PCI_BRIDGE_CFG_SVH
`define OFS_OB_XLAT 8'h00
`define OFS_OB_ATTR 8'h04
`define OFS_IB_XLAT 8'h08
`define OFS_IB_BASE 8'h0C
`define OFS_IB_ATTR 8'h10
`define OFS_IRQ_STAT 8'h14
`define OFS_IRQ_MASK 8'h18
`define OFS_BUS_FUNC 8'h44
`define ACL_BIT 0
`define ST_LAT_TERM 0
`define ST_MABORT 1
`define ST_CFG_RETRY 2
`define ST_INT_CFG 3
`define ST_W 4
`define WIN_SIZE_W 6
`define WIN_SIZE_MIN 6'h0B
`define REG_RST 32'h0000_0000
`define SIZE_RST 6'h0B
`define CMD_MEM_WRITE 4'h7
`define LINE_BYTES 6'h20
`define WORD_BYTES 6'h04
`define FIRST_IDSEL_DEV 5'h0A
`define LAT_TIMER_CLKS 32
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** design/pci_bridge_pkg.sv ***
// types shared by the pci bridge block
package pci_bridge_pkg;
   // outbound request from the local side
   typedef struct packed {
      logic cfg;          // configuration access
      logic [4:0] dev;    // device number of a configuration access
      logic [31:0] addr;  // local address or register offset
   } ob_req_type;
   // inbound request seen as pci target
   typedef struct packed {
      logic [3:0] cmd;    // pci bus command
      logic cfg;          // configuration cycle
      logic [31:0] addr;  // pci address
   } tgt_req_type;
   // latency timer states
   typedef enum logic [1:0] {
      LAT_IDLE = 2'b00,
      LAT_RUN = 2'b01,
      LAT_DATA = 2'b10
   } lat_state_type;
endpackage

// *** design/latency_timer.sv ***
// master latency timer: ends a transaction whose first data phase is late
`include "pci_bridge_cfg.svh"
module latency_timer
   import pci_bridge_pkg::*;
#(
   parameter int CLKS = `LAT_TIMER_CLKS
)
(
   input logic aclk,        // clock
   input logic aresetn,     // synchronous reset, active low
   input logic start,       // transaction begins
   input logic data_begun,  // first data phase has started
   input logic stop,        // transaction finished
   output logic expire      // pulse: terminate, timer ran out
);
   localparam int W = $clog2(CLKS + 1);
   localparam logic [W-1:0] LIM = W'(CLKS - 1);

   lat_state_type state_q; // timer state
   logic [W-1:0] cnt_q;    // clocks spent waiting for data
   logic expire_q;         // registered termination pulse

   // count clocks from start until data, stop or expiry
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= LAT_IDLE;
         cnt_q <= '0;
         expire_q <= 1'b0;
      end
      else
      begin
         expire_q <= 1'b0;
         unique case (state_q)
            LAT_IDLE:
            begin
               if (start)
               begin
                  state_q <= LAT_RUN;
                  cnt_q <= '0;
               end
            end
            LAT_RUN:
            begin
               if (stop)
                  state_q <= LAT_IDLE;
               else if (data_begun)
                  state_q <= LAT_DATA; // data started: no expiry
               else if (cnt_q == LIM)
               begin
                  expire_q <= 1'b1;
                  state_q <= LAT_IDLE;
               end
               else
                  cnt_q <= cnt_q + 1'b1;
            end
            LAT_DATA:
            begin
               if (stop)
                  state_q <= LAT_IDLE;
            end
            default:
               state_q <= LAT_IDLE; // code 2'b11 is illegal
         endcase
      end
   end

   assign expire = expire_q;

   // one clock domain: the checks below share clock and reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   lat_expire_a: assert property (
      (state_q == LAT_RUN && cnt_q == LIM && !stop && !data_begun)
      |=> expire_q)
      else $error("latency timer did not expire");
   lat_cause_a: assert property (
      expire_q |-> ($past(state_q) == LAT_RUN) && !$past(data_begun))
      else $error("expiry without a late first data phase");
   lat_early_a: assert property (
      (state_q == LAT_IDLE && start) ##1 (!stop && !data_begun) [*8]
      |-> !expire_q)
      else $error("latency timer expired early");
endmodule

// *** design/pci_host_bridge_translation_config.sv ***
// pci bridge: translation windows, target decode, config routing, registers
// Function
// - outbound address bits 31-12 from translation field; the code takes only the bits above the window size, the rest pass through
// - inbound local address upper 20 bits translated; the code translates only the bits above the window size
// - terminate when 32-clock timer expires before data
// - retry external config cycles while lock set
// - device 0 config goes to internal registers
// - devices 1-9: no idsel, type 0, abort
//
// Implementation choice: the AXI4-Lite slave port.
`include "pci_bridge_cfg.svh"
module pci_host_bridge_translation_config
   import pci_bridge_pkg::*;
#(
   parameter int AW = 8,                      // register address width
   parameter int LAT_CLKS = `LAT_TIMER_CLKS   // latency timer clocks
)
(
   input logic aclk,                  // clock, 10 MHz
   input logic aresetn,               // synchronous reset, active low
   input logic awvalid,               // write address valid
   output logic awready,              // write address ready
   input logic [AW-1:0] awaddr,       // write address
   input logic wvalid,                // write data valid
   output logic wready,               // write data ready
   input logic [31:0] wdata,          // write data
   input logic [3:0] wstrb,           // write byte strobes
   output logic bvalid,               // write response valid
   input logic bready,                // write response ready
   output logic [1:0] bresp,          // write response
   input logic arvalid,               // read address valid
   output logic arready,              // read address ready
   input logic [AW-1:0] araddr,       // read address
   output logic rvalid,               // read data valid
   input logic rready,                // read data ready
   output logic [31:0] rdata,         // read data
   output logic [1:0] rresp,          // read response
   input logic ob_valid,              // outbound request offered
   output logic ob_ready,             // outbound request accepted
   input ob_req_type ob_req,          // outbound request
   output logic pci_start,            // pulse: start pci transaction
   output logic pci_cfg,              // transaction is type 0 config
   output logic [31:0] pci_addr,      // pci address phase value
   input logic pci_data_begun,        // first data phase has begun
   input logic pci_done,              // transaction finished
   input logic pci_no_target,         // no target claimed the cycle
   output logic lat_term,             // pulse: latency timer termination
   input logic tgt_valid,             // pulse: pci cycle addressed to us
   input tgt_req_type tgt_req,        // target request
   output logic tgt_claim,            // pulse: cycle claimed
   output logic tgt_retry,            // pulse: cycle answered by retry
   output logic int_cfg,              // pulse: internal config access
   output logic loc_req,              // pulse: local memory access
   output logic [31:0] loc_addr,      // translated local address
   output logic [5:0] loc_bytes,      // bytes to fetch
   output logic loc_line,             // fetch runs to cache line end
   output logic irq                   // interrupt, active high level
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // window mask from size code: 2^(size+1) bytes, never below 4 KB except code 63, whose 6-bit shift wraps to 0
   function automatic logic [31:0] win_mask(input logic [5:0] sz);
      logic [5:0] s;
      s = (sz < `WIN_SIZE_MIN) ? `WIN_SIZE_MIN : sz;
      return 32'hFFFF_FFFF << (s + 6'h01);
   endfunction

   // byte-lane merge of a bus write into a register
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[8*i +: 8] = nw[8*i +: 8];
      return r;
   endfunction

   // software registers
   logic [31:0] ota_q;            // outbound translation address
   logic [5:0] ows_q;             // outbound window size
   logic [31:0] ita_q;            // inbound translation address
   logic [31:0] iwb_q;            // inbound window base
   logic [5:0] iws_q;             // inbound window size
   logic [`ST_W-1:0] status_q;    // sticky event bits
   logic [`ST_W-1:0] mask_q;      // interrupt enables
   logic [31:0] busfn_q;          // bus function register
   // bus slave state
   logic aw_have_q, w_have_q, ar_have_q;
   logic [AW-1:0] aw_addr_q, ar_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   // datapath registers
   logic ob_ready_q, busy_q, pci_start_q, pci_cfg_q;
   logic [31:0] pci_addr_q;
   logic tgt_claim_q, tgt_retry_q, int_cfg_q, loc_req_q, loc_line_q;
   logic [31:0] loc_addr_q;
   logic [5:0] loc_bytes_q;
   logic irq_q;
   // combinational terms
   logic wr_go, rd_go, ob_fire, ob_dev0, bus_start, agent_config_lock, ib_hit;
   logic [AW-1:0] wr_ofs, rd_ofs;
   logic [31:0] ob_m, ib_m, ob_xlat, cfg_addr, ib_xlat, rd_val;
   logic rd_err, wr_err;
   logic [`ST_W-1:0] ev, st_clr;

   assign wr_go = aw_have_q && w_have_q && !bvalid_q;
   assign rd_go = ar_have_q && !rvalid_q;
   assign wr_ofs = {aw_addr_q[AW-1:2], 2'b00};
   assign rd_ofs = {ar_addr_q[AW-1:2], 2'b00};
   assign agent_config_lock = busfn_q[`ACL_BIT];
   assign ob_m = win_mask(ows_q);
   assign ib_m = win_mask(iws_q);
   assign ob_fire = ob_valid && ob_ready_q;
   assign ob_dev0 = ob_req.cfg && (ob_req.dev == 5'h00);
   assign bus_start = ob_fire && !ob_dev0;

   // outbound: bits below the window size pass through, bits above come
   // from the translation field, so a misaligned field is simply cut
   assign ob_xlat = ({ota_q[31:12], 12'h000} & ob_m)
      | (ob_req.addr & ~ob_m);
   // type 0 config: an idsel line only for device 10 and up
   assign cfg_addr = {21'h000000, ob_req.addr[10:0]}
      | ((ob_req.dev >= `FIRST_IDSEL_DEV)
         ? (32'h0000_0001 << ob_req.dev) : 32'h0000_0000);
   // inbound: the base is compared only above the window size, which
   // relies on software aligning it; overlaps are not arbitrated
   assign ib_hit = ((tgt_req.addr ^ iwb_q) & ib_m) == 32'h0;
   assign ib_xlat = ({ita_q[31:12], 12'h000} & ib_m)
      | (tgt_req.addr & ~ib_m);

   // address write channel: one accepted at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end
      else if (awvalid && awready_q)
      begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b1;
         aw_addr_q <= awaddr;
      end
      else
      begin
         if (wr_go)
            aw_have_q <= 1'b0;
         awready_q <= !aw_have_q && !bvalid_q;
      end
   end

   // write data channel, independent of the address channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_q <= 1'b0;
         w_have_q <= 1'b0;
         w_data_q <= `REG_RST;
         w_strb_q <= 4'h0;
      end
      else if (wvalid && wready_q)
      begin
         wready_q <= 1'b0;
         w_have_q <= 1'b1;
         w_data_q <= wdata;
         w_strb_q <= wstrb;
      end
      else
      begin
         if (wr_go)
            w_have_q <= 1'b0;
         wready_q <= !w_have_q && !bvalid_q;
      end
   end

   // write decode: unmapped offsets answer slave error
   always_comb
   begin
      unique case (wr_ofs)
         `OFS_OB_XLAT, `OFS_OB_ATTR, `OFS_IB_XLAT, `OFS_IB_BASE,
         `OFS_IB_ATTR, `OFS_IRQ_STAT, `OFS_IRQ_MASK, `OFS_BUS_FUNC:
            wr_err = 1'b0;
         default:
            wr_err = 1'b1;
      endcase
   end

   // write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (bready)
         bvalid_q <= 1'b0;
   end

   // register writes
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ota_q <= `REG_RST;
         ows_q <= `SIZE_RST;
         ita_q <= `REG_RST;
         iwb_q <= `REG_RST;
         iws_q <= `SIZE_RST;
         mask_q <= '0;
         busfn_q <= `REG_RST;
      end
      else if (wr_go)
      begin
         unique case (wr_ofs)
            `OFS_OB_XLAT: ota_q <= merge(ota_q, w_data_q, w_strb_q);
            `OFS_OB_ATTR: if (w_strb_q[0]) ows_q <= w_data_q[5:0];
            `OFS_IB_XLAT: ita_q <= merge(ita_q, w_data_q, w_strb_q);
            `OFS_IB_BASE: iwb_q <= merge(iwb_q, w_data_q, w_strb_q);
            `OFS_IB_ATTR: if (w_strb_q[0]) iws_q <= w_data_q[5:0];
            `OFS_IRQ_MASK: if (w_strb_q[0]) mask_q <= w_data_q[`ST_W-1:0];
            // clearing the lock bit opens config to external masters
            `OFS_BUS_FUNC: busfn_q <= merge(busfn_q, w_data_q, w_strb_q);
            default: ; // status handled below, others ignored
         endcase
      end
   end

   // events and write-one-to-clear of status; a new event wins
   always_comb
   begin
      ev = '0;
      ev[`ST_LAT_TERM] = lat_term;
      ev[`ST_MABORT] = busy_q && pci_done && pci_no_target;
      ev[`ST_CFG_RETRY] = tgt_valid && tgt_req.cfg && agent_config_lock;
      ev[`ST_INT_CFG] = (tgt_valid && tgt_req.cfg && !agent_config_lock)
         || (ob_fire && ob_dev0);
      st_clr = '0;
      if (wr_go && (wr_ofs == `OFS_IRQ_STAT) && w_strb_q[0])
         st_clr = w_data_q[`ST_W-1:0];
   end

   // sticky status and the interrupt level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_q <= '0;
         irq_q <= 1'b0;
      end
      else
      begin
         status_q <= (status_q & ~st_clr) | ev;
         irq_q <= |(status_q & mask_q); // lags status by one clock
      end
   end

   // read address channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_q <= 1'b0;
         ar_have_q <= 1'b0;
         ar_addr_q <= '0;
      end
      else if (arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         ar_have_q <= 1'b1;
         ar_addr_q <= araddr;
      end
      else
      begin
         if (rd_go)
            ar_have_q <= 1'b0;
         arready_q <= !ar_have_q && !rvalid_q;
      end
   end

   // read mux: sizes in low bits, reserved bits read zero
   always_comb
   begin
      rd_err = 1'b0;
      unique case (rd_ofs)
         `OFS_OB_XLAT: rd_val = ota_q;
         `OFS_OB_ATTR: rd_val = {26'h0000000, ows_q};
         `OFS_IB_XLAT: rd_val = ita_q;
         `OFS_IB_BASE: rd_val = iwb_q;
         `OFS_IB_ATTR: rd_val = {26'h0000000, iws_q};
         `OFS_IRQ_STAT: rd_val = {28'h0000000, status_q};
         `OFS_IRQ_MASK: rd_val = {28'h0000000, mask_q};
         `OFS_BUS_FUNC: rd_val = busfn_q;
         default:
         begin
            rd_val = 32'h0000_0000;
            rd_err = 1'b1;
         end
      endcase
   end

   // read response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= `REG_RST;
         rresp_q <= `RESP_OKAY;
      end
      else if (rd_go)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_val;
         rresp_q <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (rready)
         rvalid_q <= 1'b0;
   end

   // outbound master: one transaction at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ob_ready_q <= 1'b0;
         busy_q <= 1'b0;
         pci_start_q <= 1'b0;
         pci_cfg_q <= 1'b0;
         pci_addr_q <= `REG_RST;
      end
      else
      begin
         ob_ready_q <= !busy_q && !ob_fire;
         pci_start_q <= bus_start; // device 0 never reaches the bus
         if (bus_start)
         begin
            busy_q <= 1'b1;
            pci_cfg_q <= ob_req.cfg;
            pci_addr_q <= ob_req.cfg ? cfg_addr : ob_xlat;
         end
         else if (pci_done || lat_term)
            busy_q <= 1'b0;
      end
   end

   // target side: retry under lock, decode, translate, prefetch length
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tgt_claim_q <= 1'b0;
         tgt_retry_q <= 1'b0;
         int_cfg_q <= 1'b0;
         loc_req_q <= 1'b0;
         loc_line_q <= 1'b0;
         loc_addr_q <= `REG_RST;
         loc_bytes_q <= 6'h00;
      end
      else
      begin
         tgt_claim_q <= tgt_valid && (tgt_req.cfg || ib_hit);
         tgt_retry_q <= tgt_valid && tgt_req.cfg && agent_config_lock;
         int_cfg_q <= ev[`ST_INT_CFG];
         loc_req_q <= tgt_valid && !tgt_req.cfg && ib_hit;
         if (tgt_valid && !tgt_req.cfg && ib_hit)
         begin
            loc_addr_q <= ib_xlat;
            // whole rest of the line is read even if the master stops
            // early: wasted reads traded for a simple fetch unit
            loc_line_q <= tgt_req.cmd == `CMD_MEM_WRITE;
            loc_bytes_q <= (tgt_req.cmd == `CMD_MEM_WRITE)
               ? `LINE_BYTES - {1'b0, ib_xlat[4:0]} : `WORD_BYTES;
         end
      end
   end

   latency_timer #(
      .CLKS(LAT_CLKS)
   ) u_lat (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(pci_start_q),
      .data_begun(pci_data_begun),
      .stop(pci_done),
      .expire(lat_term)
   );

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign ob_ready = ob_ready_q;
   assign pci_start = pci_start_q;
   assign pci_cfg = pci_cfg_q;
   assign pci_addr = pci_addr_q;
   assign tgt_claim = tgt_claim_q;
   assign tgt_retry = tgt_retry_q;
   assign int_cfg = int_cfg_q;
   assign loc_req = loc_req_q;
   assign loc_addr = loc_addr_q;
   assign loc_bytes = loc_bytes_q;
   assign loc_line = loc_line_q;
   assign irq = irq_q;

   ob_xlat_a: assert property (
      (ob_fire && !ob_req.cfg && !$stable(ota_q) == 1'b0)
      |=> pci_addr_q[31:12] == (($past(ota_q[31:12]) & ob_m[31:12])
         | ($past(ob_req.addr[31:12]) & ~ob_m[31:12])))
      else $error("outbound address not from translation field");
   ib_xlat_a: assert property (
      loc_req_q |-> loc_addr_q[11:0] == $past(tgt_req.addr[11:0])
         && (loc_addr_q[31:12] & ib_m[31:12])
            == (ita_q[31:12] & ib_m[31:12]))
      else $error("inbound local address mistranslated");
   prefetch_line_a: assert property (
      (loc_req_q && loc_line_q)
      |-> ({1'b0, loc_addr_q[4:0]} + loc_bytes_q) == `LINE_BYTES)
      else $error("memory-write fetch not to end of line");
   cfg_retry_a: assert property (
      (tgt_valid && tgt_req.cfg && agent_config_lock) |=> tgt_retry_q && !int_cfg_q)
      else $error("locked config cycle not retried");
   retry_cause_a: assert property (
      tgt_retry_q |-> $past(agent_config_lock) && $past(tgt_req.cfg))
      else $error("retry without lock");
   dev0_internal_a: assert property (
      (ob_fire && ob_dev0) |=> int_cfg_q && !pci_start_q)
      else $error("device 0 config reached the bus");
   dev_noidsel_a: assert property (
      (ob_fire && ob_req.cfg && ob_req.dev != 5'h00
         && ob_req.dev < `FIRST_IDSEL_DEV)
      |=> pci_start_q && pci_cfg_q && pci_addr_q[31:11] == 21'h000000)
      else $error("idsel raised for device 1 to 9");
   abort_flag_a: assert property (
      (busy_q && pci_done && pci_no_target) |=> status_q[`ST_MABORT]
         ##1 (irq_q || !mask_q[`ST_MABORT] || !$past(mask_q[`ST_MABORT])))
      else $error("master abort not flagged");
endmodule

// *** testbench/pci_far_end.sv ***
// model of the far pci targets: claim, answer at a set delay, or never
module pci_far_end
(
   input wire logic aclk, // clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic pci_start, // transaction starts
   input wire logic pci_cfg, // type 0 config transaction
   input wire logic [31:0] pci_addr, // address phase value
   input wire logic [7:0] dly, // clocks to first data, 8'hFF never
   output logic pci_data_begun, // first data phase begins
   output logic pci_done, // transaction ends
   output logic pci_no_target // nobody claimed the cycle
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q; // clocks since the last start, saturates
   logic hit_q; // some target claimed the cycle
   // count clocks; saturation keeps a silent target silent forever
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_q <= 8'h00;
      else if (pci_start)
         cnt_q <= 8'h01;
      else if (cnt_q != 8'h00 && cnt_q != 8'hF0)
         cnt_q <= cnt_q + 8'h01;
   end
   // config cycle with no idsel bit: no target responds
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hit_q <= 1'b0;
      else if (pci_start)
         hit_q <= !pci_cfg || (pci_addr[31:11] != 21'h0);
   end
   assign pci_data_begun = hit_q && cnt_q == dly;
   assign pci_done = hit_q ? (dly != 8'hFF && cnt_q == dly + 8'h01)
                           : cnt_q == 8'h06;
   assign pci_no_target = !hit_q && cnt_q == 8'h06;
endmodule

// *** testbench/pci_host_bridge_translation_config_tb.sv ***
// self-checking bench of the pci bridge with a queue scoreboard
`include "pci_bridge_cfg.svh"
module pci_host_bridge_translation_config_tb;
   import pci_bridge_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, ob_valid = 0, tgt_valid = 0, probe = 0;
   logic [7:0] awaddr = 0, araddr = 0, dly = 8'h03; // dly: far side delay
   logic [3:0] wstrb = 4'hF; // whole words only
   logic [31:0] wdata = 0, seed = 32'h1F61, a, t, b, m, c;
   ob_req_type ob_req = '0; // outbound request
   tgt_req_type tgt_req = '0; // inbound request
   logic awready, wready, bvalid, arready, rvalid, ob_ready, pci_start;
   logic pci_cfg, pci_data_begun, pci_done, pci_no_target, lat_term;
   logic tgt_claim, tgt_retry, int_cfg, loc_req, loc_line, irq;
   logic [1:0] bresp, rresp; // responses
   logic [31:0] rdata, pci_addr, loc_addr; // data and addresses
   logic [5:0] loc_bytes; // fetch length
   int bad_count = 0, checked = 0, n, sc;
   int dv_list[4] = '{0, 1, 9, 12}; // config device numbers tried
   logic [39:0] q[$]; // expected results, oldest first
   pci_host_bridge_translation_config dut (.*);
   pci_far_end far (.*);
   initial forever #50 aclk = ~aclk;
   // xorshift source of stimulus values
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic print_verdict();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0 && q.size() == 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // one clock; a wait that runs too long ends the run
   task automatic tick();
      @(posedge aclk);
      n++;
      if (n > 300)
      begin
         bad_count++;
         print_verdict();
      end
   endtask
   task automatic ex(input logic [7:0] k, input logic [31:0] v);
      q.push_back({k, v});
   endtask
   task automatic see(input logic [7:0] k, input logic [31:0] v);
      logic [39:0] e;
      checked++;
      e = q.size() ? q.pop_front() : 40'hFF_FFFF_FFFF;
      if (e !== {k, v})
      begin
         bad_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, {k, v});
      end
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d,
                     input logic [1:0] r);
      ex({6'h08, r}, 32'h0);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      n = 0;
      do
      begin
         tick();
         if (awready)
            awvalid <= 0;
         if (wready)
            wvalid <= 0;
      end while (bvalid !== 1);
      bready <= 0;
      tick();
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] d,
                     input logic [1:0] r);
      ex({6'h04, r}, d);
      araddr <= ad;
      arvalid <= 1;
      rready <= 1;
      n = 0;
      do
      begin
         tick();
         if (arready)
            arvalid <= 0;
      end while (rvalid !== 1);
      rready <= 0;
      tick();
   endtask
   // offer an outbound request, then wait until the bridge is idle again
   task automatic ob(input logic cf, input logic [4:0] dv,
                     input logic [31:0] ad);
      ob_req <= {cf, dv, ad};
      ob_valid <= 1;
      n = 0;
      do tick(); while (ob_ready !== 1);
      ob_valid <= 0;
      do tick(); while (ob_ready !== 1);
   endtask
   task automatic tg(input logic [3:0] cm, input logic cf,
                     input logic [31:0] ad);
      tgt_req <= {cm, cf, ad};
      tgt_valid <= 1;
      n = 0;
      tick();
      tgt_valid <= 0;
      tick();
      tick();
   endtask
   // irq sampled on demand, after the status has had time to settle
   task automatic pr(input logic v);
      n = 0;
      repeat (3) tick();
      ex(8'h0D, {31'h0, v});
      probe <= 1;
      tick();
      probe <= 0;
   endtask
   // monitor: every result taken off the outputs meets the oldest note
   always @(posedge aclk)
   begin
      sc = pci_start === 1 ? 0 : sc + 1;
      if (aresetn === 1)
      begin
         if (rvalid === 1 && rready === 1)
            see({6'h04, rresp}, rdata);
         if (bvalid === 1 && bready === 1)
            see({6'h08, bresp}, 32'h0);
         if (pci_start === 1)
            see({7'h01, pci_cfg}, pci_addr);
         if (loc_req === 1)
            see({tgt_claim, loc_line, loc_bytes}, loc_addr);
         if (int_cfg === 1)
            see(8'h0A, {31'h0, tgt_claim});
         if (tgt_retry === 1)
            see(8'h0B, {31'h0, tgt_claim});
         if (lat_term === 1)
            see(8'h0C, sc);
         if (probe === 1)
            see(8'h0D, {31'h0, irq});
      end
   end
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      rd(`OFS_OB_ATTR, {26'h0, `SIZE_RST}, `RESP_OKAY);
      rd(8'h40, 32'h0, `RESP_SLVERR);
      wr(8'h40, rnd(), `RESP_SLVERR);
      $display("test registers done");
      for (int s = 11; s < 14; s += 2)
      begin
         m = 32'hFFFF_FFFF << (s + 1);
         t = rnd() & m; // aligned to the window size
         wr(`OFS_OB_ATTR, s, `RESP_OKAY);
         wr(`OFS_OB_XLAT, t, `RESP_OKAY);
         a = rnd();
         ex(8'h02, t | (a & ~m));
         ob(0, 5'h00, a);
      end
      foreach (dv_list[i])
      begin
         a = rnd();
         if (dv_list[i] == 0)
            ex(8'h0A, 32'h0);
         else
            ex(8'h03, {21'h0, a[10:0]}
               | (dv_list[i] > 9 ? 1 << dv_list[i] : 0));
         ob(1, dv_list[i][4:0], a);
      end
      dly <= 8'd20; // slow first data, inside the timer
      ex(8'h02, t | (a & ~m));
      ob(0, 5'h00, a);
      dly <= 8'hFF; // target never reaches a data phase
      ex(8'h02, t | (a & ~m));
      ex(8'h0C, `LAT_TIMER_CLKS + 1);
      ob(0, 5'h00, a);
      $display("test outbound done");
      wr(`OFS_BUS_FUNC, 32'h1, `RESP_OKAY);
      ex(8'h0B, 32'h1);
      tg(4'hB, 1, rnd());
      wr(`OFS_BUS_FUNC, 32'h0, `RESP_OKAY);
      ex(8'h0A, 32'h1);
      tg(4'hB, 1, rnd());
      // one window each way, so overlapping windows cannot arise
      b = rnd() & 32'hFFFF_F000; // base aligned to 4 KB
      t = rnd() & 32'hFFFF_F000;
      wr(`OFS_IB_BASE, b, `RESP_OKAY);
      wr(`OFS_IB_XLAT, t, `RESP_OKAY);
      for (int cm = 6; cm < 8; cm++)
      begin
         a = b | (rnd() & 32'h0000_0FFF);
         c = cm == 7 ? 32'h20 - a[4:0] : 32'h04;
         ex({1'b1, cm == 7, c[5:0]}, t | (a & 32'h0000_0FFF));
         tg(cm[3:0], 0, a);
      end
      tg(`CMD_MEM_WRITE, 0, b ^ 32'h0000_1000);
      $display("test inbound done");
      rd(`OFS_IRQ_STAT, 32'hF, `RESP_OKAY);
      pr(0);
      wr(`OFS_IRQ_MASK, 32'h1, `RESP_OKAY);
      pr(1);
      wr(`OFS_IRQ_STAT, 32'h1, `RESP_OKAY);
      pr(0);
      rd(`OFS_IRQ_STAT, 32'hE, `RESP_OKAY);
      $display("test interrupts done");
      print_verdict();
   end
endmodule
